// ### hdl/lpm_cfg.svh
/*
  Constants of the low-power mode controller: register offsets, field
  positions, reset values and timing counts.
  Assumes a 20 MHz controller clock and a byte-addressed register port.
*/
`ifndef LPM_CFG_SVH
`define LPM_CFG_SVH

// Register offsets (byte addresses)
`define LPM_OFS_CTRL 8'h00
`define LPM_OFS_FREQ 8'h04
`define LPM_OFS_STAT 8'h08
`define LPM_OFS_IRQ_STAT 8'h0c
`define LPM_OFS_IRQ_MASK 8'h10
`define LPM_OFS_WAKE_EN 8'h14

// Control field positions
`define LPM_CTRL_MODE_LSB 0
`define LPM_CTRL_RANGE_LSB 4
`define LPM_CTRL_RTC_BIT 6
`define LPM_CTRL_GO_BIT 7
`define LPM_CTRL_SRC_LSB 8
`define LPM_CTRL_MSI_LSB 12
`define LPM_CTRL_REF_BIT 15

// Reset values
`define LPM_CTRL_RESET 32'h0000_5010
`define LPM_MASK_RESET 8'h00
`define LPM_FREQ_RESET 32'd2100
`define LPM_WAKE_EN_RESET 5'h1f

// Frequency limits in kHz
`define LPM_R1_MAX_KHZ 32'd32000
`define LPM_R2_MAX_KHZ 32'd16000
`define LPM_R3_MAX_KHZ 32'd4200
`define LPM_R1_WS_KHZ 32'd16000
`define LPM_R2_WS_KHZ 32'd8000
`define LPM_R3_WS_KHZ 32'd2100
`define LPM_LPRUN_MAX_KHZ 32'd131

// Timing
`define LPM_CLK_KHZ 20000
`define LPM_STEP_GAP_NS 5000
`define LPM_STEP_GAP_CYC ((`LPM_STEP_GAP_NS * `LPM_CLK_KHZ + 999999) / 1000000)
`define LPM_STOP_WAKE_NS 8000
`define LPM_STOP_WAKE_CYC ((`LPM_STOP_WAKE_NS * `LPM_CLK_KHZ) / 1000000)
`define LPM_STBY_WAKE_NS 60000
`define LPM_STBY_WAKE_CYC ((`LPM_STBY_WAKE_NS * `LPM_CLK_KHZ) / 1000000)
`define LPM_REG_SETTLE_CYC 4

`endif

// ### hdl/lpm_pkg.sv
/*
  Types of the low-power mode controller.
  Assumes lpm_cfg.svh is included beside it.
*/
`default_nettype none
package lpm_pkg;
  // Requested low-power mode
  typedef enum logic [2:0] {
    MODE_RUN, MODE_SLEEP, MODE_LPRUN, MODE_LPSLEEP, MODE_STOP, MODE_STANDBY
  } lp_mode_t;
  // Sequencer state
  typedef enum logic [2:0] {
    ST_RUN, ST_HALT, ST_LOWER, ST_IDLE, ST_RESTORE, ST_CLKON
  } seq_state_t;
  // CPU clock source
  typedef enum logic [1:0] {
    SRC_MSI, SRC_FAST_INT, SRC_FAST_XTAL, SRC_PLL
  } clk_src_t;
endpackage
`default_nettype wire

// ### hdl/low_power_mode_controller.sv
/*
  Low-power mode controller: voltage range and clock limits, flash wait
  states, frequency-step pacing, and sequencing of sleep, low-power run,
  low-power sleep, stop and standby with wakeup collection.
  Assumes a 20 MHz clock, a synchronous register port, and that event
  inputs are asynchronous and pass two flip-flops before use.
*/
// Our own choices: strobed register access and the address map.
// Behaviour
// R1 - CPU clock capped at 32/16/4 MHz per range
// R2 - Range three runs only from multispeed oscillator
// R3 - Wait state chosen from range and frequency
// R4 - Software steps under 4x, 5 us apart
// R5 - Sleep halts CPU only, any interrupt wakes
// R6 - Low-power run needs slow multispeed, regulator low
// R7 - Low-power sleep wakes to run, regulator full
// R8 - Stop with clock: fast oscillators off, slow on
// R9 - Event lines, detector, comparators wake stop in 8 us
// R10 - Clock-domain events also wake stop with clock
// R11 - Stop without clock: all off, fewer sources
// R12 - Standby: regulator off, core unpowered, retention only
// R13 - Standby with clock: pins, watchdog, clock events exit
// R14 - Standby without clock: reset pin or wake pin
// R15 - Clock and watchdog sources survive stop/standby
// R16 - Regulator down after halt, up before clocks
`timescale 1ns/1ps
`default_nettype none
`include "lpm_cfg.svh"

module low_power_mode_controller
  import lpm_pkg::*;
#(
  parameter int STBY_WAKE_CYC = `LPM_STBY_WAKE_CYC
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic write_i,
  input wire logic read_i,
  output logic [31:0] rdata_o,
  output logic irq_o,
  input wire logic cpu_sleeping_i,
  input wire logic cpu_irq_i,
  input wire logic [15:0] external_event_line_i,
  input wire logic voltage_detector_out_i,
  input wire logic [1:0] comparator_event_i,
  input wire logic usb_wakeup_i,
  input wire logic [4:0] clock_domain_event_i,
  input wire logic [1:0] standby_wake_pin_i,
  input wire logic external_reset_pin_n_i,
  input wire logic independent_watchdog_reset_i,
  output logic cpu_clock_en_o,
  output logic periph_clock_en_o,
  output logic regulator_low_o,
  output logic regulator_off_o,
  output logic core_power_off_o,
  output logic multispeed_internal_osc_en_o,
  output logic fast_internal_osc_en_o,
  output logic fast_crystal_osc_en_o,
  output logic pll_en_o,
  output logic slow_internal_osc_en_o,
  output logic slow_crystal_osc_en_o,
  output logic [1:0] cpu_clk_src_o,
  output logic flash_wait_state_o,
  output logic standby_exit_o
);

  // Number of synchronised event inputs
  localparam int NEV = 30;
  // Control register image after reset
  localparam logic [31:0] CTRL_RST = `LPM_CTRL_RESET;

  // Control register fields
  logic [2:0] mode_req;
  logic [1:0] range;
  logic rtc_on;
  logic [1:0] src_req;
  logic [2:0] msi_range;
  logic vref_on;
  logic [31:0] freq_khz;
  logic [4:0] wake_en;
  logic [7:0] irq_stat;
  logic [7:0] irq_mask;
  // Sequencer
  seq_state_t state;
  lp_mode_t mode_act;
  logic [11:0] wait_cnt;
  logic [11:0] gap_cnt;
  // Event synchronisers
  logic [NEV-1:0] ev_meta;
  logic [NEV-1:0] ev_sync;
  logic [1:0] pin_last;
  logic [NEV-1:0] ev_raw;
  // Decoded events
  logic wake_stop;
  logic wake_stby;
  logic step_bad;
  logic freq_ok;
  logic wr_ctrl;
  logic wr_freq;
  logic [7:0] events;

  assign ev_raw = {~external_reset_pin_n_i, independent_watchdog_reset_i,
                   standby_wake_pin_i, clock_domain_event_i, usb_wakeup_i,
                   comparator_event_i, voltage_detector_out_i,
                   cpu_irq_i, external_event_line_i};

  // Two-flop synchroniser for every outside event
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ev_meta <= '0;
      ev_sync <= '0;
      pin_last <= '0;
    end else begin
      ev_meta <= ev_raw;
      ev_sync <= ev_meta;
      pin_last <= ev_sync[27:26];
    end
  end

  // Wake sources for stop mode
  always_comb begin
    // R9 - event lines, detector, comparators
    wake_stop = |ev_sync[15:0] | ev_sync[17] |
                (vref_on & |ev_sync[19:18]);
    // R11 - USB wakeup in either stop flavour
    wake_stop = wake_stop | ev_sync[20];
    // R10 - clock-domain events with clock kept
    if (rtc_on) begin
      wake_stop = wake_stop | |(ev_sync[25:21] & wake_en);
    end
  end

  // Wake sources for standby mode
  always_comb begin
    // R14 - reset pin or rising wake pin
    wake_stby = ev_sync[29] | |(ev_sync[27:26] & ~pin_last);
    // R13 - watchdog and clock events with clock kept
    if (rtc_on) begin
      wake_stby = wake_stby | ev_sync[28] | |ev_sync[25:21];
    end
  end

  // Frequency checks on a software write
  always_comb begin
    // R1 - per-range ceiling
    unique case (range)
      2'd1: freq_ok = wdata_i <= `LPM_R1_MAX_KHZ;
      2'd2: freq_ok = wdata_i <= `LPM_R2_MAX_KHZ;
      default: freq_ok = wdata_i <= `LPM_R3_MAX_KHZ;
    endcase
    // R4 - step under four times, and spaced
    step_bad = (wdata_i > freq_khz && freq_khz != 32'h0 &&
                wdata_i >= {freq_khz[29:0], 2'b00}) || gap_cnt != 12'h0;
  end

  assign wr_ctrl = write_i && addr_i == `LPM_OFS_CTRL;
  assign wr_freq = write_i && addr_i == `LPM_OFS_FREQ;

  // Control register and frequency register
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mode_req <= CTRL_RST[`LPM_CTRL_MODE_LSB +: 3];
      range <= CTRL_RST[`LPM_CTRL_RANGE_LSB +: 2];
      rtc_on <= CTRL_RST[`LPM_CTRL_RTC_BIT];
      src_req <= CTRL_RST[`LPM_CTRL_SRC_LSB +: 2];
      msi_range <= CTRL_RST[`LPM_CTRL_MSI_LSB +: 3];
      vref_on <= CTRL_RST[`LPM_CTRL_REF_BIT];
      freq_khz <= `LPM_FREQ_RESET;
      wake_en <= `LPM_WAKE_EN_RESET;
    end else begin
      if (wr_ctrl && state == ST_RUN) begin
        mode_req <= wdata_i[`LPM_CTRL_MODE_LSB +: 3];
        range <= (wdata_i[`LPM_CTRL_RANGE_LSB +: 2] == 2'd0) ? 2'd1 :
                 wdata_i[`LPM_CTRL_RANGE_LSB +: 2];
        rtc_on <= wdata_i[`LPM_CTRL_RTC_BIT];
        src_req <= wdata_i[`LPM_CTRL_SRC_LSB +: 2];
        msi_range <= wdata_i[`LPM_CTRL_MSI_LSB +: 3];
        vref_on <= wdata_i[`LPM_CTRL_REF_BIT];
      end
      // R1 - refuse a frequency above the range
      if (wr_freq && freq_ok && !step_bad) begin
        freq_khz <= wdata_i;
      end
      if (write_i && addr_i == `LPM_OFS_WAKE_EN) begin
        wake_en <= wdata_i[4:0];
      end
    end
  end

  // R4 - pacing counter between frequency steps
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      gap_cnt <= 12'h0;
    end else if (wr_freq && freq_ok && !step_bad) begin
      gap_cnt <= 12'(`LPM_STEP_GAP_CYC);
    end else if (gap_cnt != 12'h0) begin
      gap_cnt <= gap_cnt - 12'h1;
    end
  end

  // Mode sequencer
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state <= ST_RUN;
      mode_act <= MODE_RUN;
      wait_cnt <= 12'h0;
    end else begin
      unique case (state)
        ST_RUN: begin
          mode_act <= MODE_RUN;
          if (wr_ctrl && wdata_i[`LPM_CTRL_GO_BIT]) begin
            mode_act <= lp_mode_t'(wdata_i[`LPM_CTRL_MODE_LSB +: 3]);
            // R6 - low-power run needs slow multispeed
            if (wdata_i[`LPM_CTRL_MODE_LSB +: 3] == 3'(MODE_LPRUN)) begin
              if (src_req == 2'(SRC_MSI) && msi_range <= 3'h1 &&
                  freq_khz <= `LPM_LPRUN_MAX_KHZ) begin
                state <= ST_IDLE;
              end
            end else if (wdata_i[`LPM_CTRL_MODE_LSB +: 3] != 3'h0) begin
              state <= ST_HALT;
            end
          end
        end
        // R16 - wait for CPU halt before lowering
        ST_HALT: if (cpu_sleeping_i) begin
          state <= ST_LOWER;
        end
        ST_LOWER: state <= ST_IDLE;
        ST_IDLE: begin
          wait_cnt <= 12'h0;
          unique case (mode_act)
            // R5 - any interrupt wakes sleep
            MODE_SLEEP, MODE_LPSLEEP: if (ev_sync[16]) begin
              state <= ST_RESTORE;
            end
            MODE_LPRUN: if (wr_ctrl && !wdata_i[`LPM_CTRL_GO_BIT]) begin
              state <= ST_RESTORE;
            end
            MODE_STOP: if (wake_stop) begin
              state <= ST_RESTORE;
            end
            MODE_STANDBY: if (wake_stby) begin
              state <= ST_RESTORE;
            end
            default: state <= ST_RESTORE;
          endcase
        end
        // R16 - regulator restored first, then clocks
        ST_RESTORE: begin
          wait_cnt <= wait_cnt + 12'h1;
          if (wait_cnt >= 12'(`LPM_REG_SETTLE_CYC)) begin
            state <= ST_CLKON;
            wait_cnt <= 12'h0;
          end
        end
        ST_CLKON: begin
          wait_cnt <= wait_cnt + 12'h1;
          // R9 - stop exit inside 8 us
          // R13 - standby exit inside 60 us
          if (mode_act != MODE_STANDBY ||
              wait_cnt >= 12'(STBY_WAKE_CYC - `LPM_STOP_WAKE_CYC)) begin
            state <= ST_RUN;
          end
        end
      endcase
    end
  end

  // Output stage, all registered
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cpu_clock_en_o <= 1'b1;
      periph_clock_en_o <= 1'b1;
      regulator_low_o <= 1'b0;
      regulator_off_o <= 1'b0;
      core_power_off_o <= 1'b0;
      multispeed_internal_osc_en_o <= 1'b1;
      fast_internal_osc_en_o <= 1'b0;
      fast_crystal_osc_en_o <= 1'b0;
      pll_en_o <= 1'b0;
      slow_internal_osc_en_o <= 1'b1;
      slow_crystal_osc_en_o <= 1'b0;
      cpu_clk_src_o <= 2'(SRC_MSI);
      flash_wait_state_o <= 1'b0;
      standby_exit_o <= 1'b0;
    end else begin
      // R5 - sleep gates only the CPU clock
      cpu_clock_en_o <= state == ST_RUN ||
                        (state == ST_IDLE && mode_act == MODE_LPRUN);
      periph_clock_en_o <= !(state inside {ST_LOWER, ST_IDLE} &&
                             mode_act inside {MODE_STOP, MODE_STANDBY});
      // R7 - regulator low in low-power modes only
      regulator_low_o <= state inside {ST_LOWER, ST_IDLE} &&
                         mode_act != MODE_SLEEP;
      // R12 - standby removes core power
      regulator_off_o <= state == ST_IDLE && mode_act == MODE_STANDBY;
      core_power_off_o <= state == ST_IDLE && mode_act == MODE_STANDBY;
      // R8 - fast oscillators off in stop and standby
      if (state inside {ST_LOWER, ST_IDLE} &&
          mode_act inside {MODE_STOP, MODE_STANDBY}) begin
        multispeed_internal_osc_en_o <= 1'b0;
        fast_internal_osc_en_o <= 1'b0;
        fast_crystal_osc_en_o <= 1'b0;
        pll_en_o <= 1'b0;
        // R15 - slow sources stay with clock kept
        // R11 - all off without the clock
        slow_internal_osc_en_o <= rtc_on;
        slow_crystal_osc_en_o <= rtc_on;
      end else if (state inside {ST_RUN, ST_CLKON}) begin
        // R2 - range three only on multispeed
        multispeed_internal_osc_en_o <= 1'b1;
        fast_internal_osc_en_o <= range != 2'd3 && src_req != 2'(SRC_MSI);
        fast_crystal_osc_en_o <= range != 2'd3 && src_req == 2'(SRC_FAST_XTAL);
        pll_en_o <= range != 2'd3 && src_req == 2'(SRC_PLL);
        slow_internal_osc_en_o <= 1'b1;
        slow_crystal_osc_en_o <= rtc_on;
        cpu_clk_src_o <= (range == 2'd3) ? 2'(SRC_MSI) : src_req;
      end
      // R3 - wait state per range and frequency
      unique case (range)
        2'd1: flash_wait_state_o <= freq_khz > `LPM_R1_WS_KHZ;
        2'd2: flash_wait_state_o <= freq_khz > `LPM_R2_WS_KHZ;
        default: flash_wait_state_o <= freq_khz > `LPM_R3_WS_KHZ;
      endcase
      standby_exit_o <= state == ST_IDLE && mode_act == MODE_STANDBY &&
                        wake_stby;
    end
  end

  assign events = {2'b00, step_bad & wr_freq, ~freq_ok & wr_freq,
                   wake_stby & state == ST_IDLE,
                   wake_stop & state == ST_IDLE,
                   state == ST_CLKON, state == ST_LOWER};

  // Sticky status, write one to clear, set wins
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      irq_stat <= 8'h00;
      irq_mask <= `LPM_MASK_RESET;
      irq_o <= 1'b0;
    end else begin
      irq_stat <= (irq_stat &
                   ~((write_i && addr_i == `LPM_OFS_IRQ_STAT) ? wdata_i[7:0]
                                                                : 8'h00))
                  | events;
      if (write_i && addr_i == `LPM_OFS_IRQ_MASK) begin
        irq_mask <= wdata_i[7:0];
      end
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  // Read port, data one cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0;
    end else if (read_i) begin
      unique case (addr_i)
        `LPM_OFS_CTRL: rdata_o <= {16'h0, vref_on, msi_range, 2'b00,
                                   src_req, 1'b0, rtc_on, range, 1'b0,
                                   mode_req};
        `LPM_OFS_FREQ: rdata_o <= freq_khz;
        `LPM_OFS_STAT: rdata_o <= {25'h0, flash_wait_state_o,
                                   1'(mode_act != MODE_RUN), 2'b00,
                                   state};
        `LPM_OFS_IRQ_STAT: rdata_o <= {24'h0, irq_stat};
        `LPM_OFS_IRQ_MASK: rdata_o <= {24'h0, irq_mask};
        `LPM_OFS_WAKE_EN: rdata_o <= {27'h0, wake_en};
        default: rdata_o <= 32'h0;
      endcase
    end else begin
      rdata_o <= 32'h0;
    end
  end

endmodule // low_power_mode_controller

`default_nettype wire

// ### tb/lpm_monitor.sv
/*
  Port checker for the low-power mode controller.
  Assumes one clock domain and a bind to the controller by port name.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lpm_cfg.svh"
module lpm_monitor #(
  parameter int STBY_WAKE_CYC = `LPM_STBY_WAKE_CYC
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic read_i,
  input wire logic [31:0] rdata_o,
  input wire logic cpu_clock_en_o,
  input wire logic periph_clock_en_o,
  input wire logic regulator_low_o,
  input wire logic regulator_off_o,
  input wire logic core_power_off_o,
  input wire logic multispeed_internal_osc_en_o,
  input wire logic fast_internal_osc_en_o,
  input wire logic fast_crystal_osc_en_o,
  input wire logic pll_en_o,
  input wire logic [15:0] external_event_line_i,
  input wire logic [1:0] standby_wake_pin_i,
  input wire logic standby_exit_o
);
  localparam int STOP_WAKE_CYC = `LPM_STOP_WAKE_CYC; // Stop exit bound
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  chk_osc_after_halt:
    assert property ($fell(multispeed_internal_osc_en_o) |-> !cpu_clock_en_o)
    else $error("oscillator gated while cpu clocked");
  chk_fast_after_reg:
    assert property ($rose(fast_internal_osc_en_o) || $rose(pll_en_o) ||
      $rose(fast_crystal_osc_en_o) |-> !regulator_low_o && !regulator_off_o)
    else $error("fast clock enabled on weak regulator");
  chk_halt_keeps_periph:
    assert property ($fell(cpu_clock_en_o) |-> periph_clock_en_o)
    else $error("peripheral clock gone at cpu halt");
  chk_wake_reg_full:
    assert property ($rose(cpu_clock_en_o) |-> !regulator_low_o &&
      !regulator_off_o && !core_power_off_o)
    else $error("cpu restarted before regulator restored");
  chk_power_off_reg:
    assert property (core_power_off_o |-> regulator_off_o && !cpu_clock_en_o)
    else $error("core unpowered with regulator on");
  chk_standby_osc_off:
    assert property (regulator_off_o [*4] |-> !pll_en_o &&
      !fast_internal_osc_en_o && !fast_crystal_osc_en_o &&
      !multispeed_internal_osc_en_o)
    else $error("fast oscillator alive in standby");
  chk_stop_wake_time:
    assert property ($rose(|external_event_line_i) && regulator_low_o &&
      !regulator_off_o && !cpu_clock_en_o && !multispeed_internal_osc_en_o
      |-> ##[1:STOP_WAKE_CYC] cpu_clock_en_o)
    else $error("stop wake too slow");
  chk_wake_pin_seen:
    assert property ($rose(standby_wake_pin_i[0]) && core_power_off_o
      |-> ##[1:8] standby_exit_o)
    else $error("standby wake pin ignored");
  int exit_cnt; // Cycles from standby exit to cpu clock
  // Count the standby exit latency, too long for a delay range
  always_ff @(posedge clock_i) begin
    if (rst_i || cpu_clock_en_o) begin
      exit_cnt <= 0;
    end else if (standby_exit_o || exit_cnt != 0) begin
      exit_cnt <= exit_cnt + 1;
    end
  end
  chk_standby_exit_time:
    assert property (exit_cnt <= STBY_WAKE_CYC)
    else $error("standby exit too slow");
  // Read data only after a read strobe
  chk_read_idle_zero:
    assert property (!read_i |=> rdata_o == 32'h0)
    else $error("read data without read strobe");
endmodule // lpm_monitor
bind low_power_mode_controller lpm_monitor #(
  .STBY_WAKE_CYC(STBY_WAKE_CYC)
) mon (.*);
`default_nettype wire

// ### tb/lpm_cpu_model.sv
/*
  Processor core stand-in: reports itself halted a few cycles after its
  clock is gated, and running again once the clock returns.
  Assumes the controller clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module lpm_cpu_model #(
  parameter int HALT_LAG = 2 // Cycles to finish the last instruction
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic cpu_clock_en_i,
  output logic cpu_sleeping_o
);
  int lag; // Cycles since the clock was gated
  // Halt report follows the gated clock after the lag
  always_ff @(posedge clock_i) begin
    if (rst_i || cpu_clock_en_i) begin
      lag <= 0;
      cpu_sleeping_o <= 1'b0;
    end else if (lag < HALT_LAG) begin
      lag <= lag + 1;
    end else begin
      cpu_sleeping_o <= 1'b1;
    end
  end
endmodule // lpm_cpu_model
`default_nettype wire

// ### tb/tb_top.sv
/*
  Bench for the low-power mode controller: registers, frequency steps,
  interrupt, and each low-power mode with its wakeups.
  Assumes design files, cpu model and checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lpm_cfg.svh"
module tb_top;
  import lpm_pkg::*;
  localparam int STBY = 170; // Shortened standby exit count
  logic clock_i = 1'b0, rst_i = 1'b1, write_i = 1'b0, read_i = 1'b0;
  logic cpu_irq_i = 1'b0, usb_wakeup_i = 1'b0, voltage_detector_out_i = 1'b0;
  logic external_reset_pin_n_i = 1'b1, independent_watchdog_reset_i = 1'b0;
  logic [7:0] addr_i = 8'h0;
  logic [31:0] wdata_i = 32'h0, rdata_o;
  logic [15:0] external_event_line_i = 16'h0;
  logic [4:0] clock_domain_event_i = 5'h0;
  logic [1:0] comparator_event_i = 2'h0, standby_wake_pin_i = 2'h0;
  logic [1:0] cpu_clk_src_o;
  logic cpu_sleeping_i, irq_o, cpu_clock_en_o, periph_clock_en_o;
  logic regulator_low_o, regulator_off_o, core_power_off_o, standby_exit_o;
  logic multispeed_internal_osc_en_o, fast_internal_osc_en_o, pll_en_o;
  logic fast_crystal_osc_en_o, slow_internal_osc_en_o, slow_crystal_osc_en_o;
  logic flash_wait_state_o;
  logic [5:0] clk_st; // Clock enables seen in low-power modes
  int errors = 0, total_checks = 0, cycles = 0;
  assign clk_st = {periph_clock_en_o, multispeed_internal_osc_en_o,
    fast_internal_osc_en_o, fast_crystal_osc_en_o, pll_en_o,
    slow_internal_osc_en_o};
  low_power_mode_controller #(.STBY_WAKE_CYC(STBY)) dut (.*);
  lpm_cpu_model cpu (.clock_i(clock_i), .rst_i(rst_i),
    .cpu_clock_en_i(cpu_clock_en_o), .cpu_sleeping_o(cpu_sleeping_i));
  // Clock and hang guard
  always #25 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 10000) begin
      errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic settle(int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  // One-cycle write then a quiet cycle
  task automatic wr(logic [7:0] a, logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    write_i <= 1'b1;
    @(posedge clock_i);
    write_i <= 1'b0;
    @(posedge clock_i);
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m = '1);
    addr_i <= a;
    read_i <= 1'b1;
    @(posedge clock_i);
    read_i <= 1'b0;
    #1 check("read data", rdata_o & m, e);
    @(posedge clock_i);
  endtask
  task automatic wait_cpu(logic v, int lim);
    int n;
    n = 0;
    #1;
    while (cpu_clock_en_o !== v && n < lim) begin
      @(posedge clock_i);
      #1 n++;
    end
    check("cpu clock", cpu_clock_en_o, v);
  endtask
  task automatic enter(logic [31:0] c);
    wr(`LPM_OFS_CTRL, c);
    wait_cpu(1'b0, 8);
    settle(12);
  endtask
  // Wait for wake, then drop every wake source
  task automatic wake(int lim);
    wait_cpu(1'b1, lim);
    cpu_irq_i <= 1'b0;
    usb_wakeup_i <= 1'b0;
    external_event_line_i <= 16'h0;
    clock_domain_event_i <= 5'h0;
    standby_wake_pin_i <= 2'h0;
    comparator_event_i <= 2'h0;
    voltage_detector_out_i <= 1'b0;
    independent_watchdog_reset_i <= 1'b0;
    external_reset_pin_n_i <= 1'b1;
    settle(4);
  endtask
  initial begin
    settle(3);
    rst_i <= 1'b0;
    settle(1);
    check("reset outs", {cpu_clock_en_o, periph_clock_en_o, clk_st[4],
      slow_internal_osc_en_o, fast_internal_osc_en_o, fast_crystal_osc_en_o,
      pll_en_o, slow_crystal_osc_en_o, regulator_low_o, regulator_off_o,
      core_power_off_o, irq_o}, 12'hf00);
    rd(`LPM_OFS_FREQ, 32'h834);
    rd(`LPM_OFS_IRQ_MASK, 32'h0);
    wr(8'h40, 32'hffff_ffff); // Unmapped
    rd(`LPM_OFS_CTRL, `LPM_CTRL_RESET);
    wr(`LPM_OFS_CTRL, 32'h130);
    settle(2);
    check("clock source", cpu_clk_src_o, 2'h0);
    wr(`LPM_OFS_CTRL, 32'h110);
    settle(2);
    check("fast source", {cpu_clk_src_o, fast_internal_osc_en_o}, 3'h3);
    wr(`LPM_OFS_CTRL, 32'h10);
    settle(110);
    wr(`LPM_OFS_FREQ, 32'h2328);
    rd(`LPM_OFS_FREQ, 32'h834);
    wr(`LPM_OFS_FREQ, 32'h1f40);
    wr(`LPM_OFS_FREQ, 32'h2328);
    rd(`LPM_OFS_FREQ, 32'h1f40);
    check("wait state", flash_wait_state_o, 1'b0);
    settle(110);
    wr(`LPM_OFS_FREQ, 32'h4e20);
    settle(110);
    check("wait state", flash_wait_state_o, 1'b1);
    wr(`LPM_OFS_FREQ, 32'h9c40);
    rd(`LPM_OFS_FREQ, 32'h4e20);
    rd(`LPM_OFS_IRQ_STAT, 32'h30, 32'h30);
    check("irq", irq_o, 1'b0);
    wr(`LPM_OFS_IRQ_MASK, 32'h20);
    settle(1);
    check("irq", irq_o, 1'b1);
    wr(`LPM_OFS_IRQ_STAT, 32'h20);
    settle(1);
    check("irq", irq_o, 1'b0);
    rd(`LPM_OFS_IRQ_STAT, 32'h10, 32'h30);
    wr(`LPM_OFS_CTRL, 32'h92);
    settle(8);
    check("regulator low", regulator_low_o, 1'b0);
    wr(`LPM_OFS_FREQ, 32'h64);
    wr(`LPM_OFS_CTRL, 32'h92);
    settle(8);
    check("low run", {regulator_low_o, cpu_clock_en_o}, 2'h3);
    rd(`LPM_OFS_STAT, 32'h23);
    wr(`LPM_OFS_CTRL, 32'h12);
    settle(8);
    check("regulator low", regulator_low_o, 1'b0);
    enter(32'h91);
    check("sleep", {periph_clock_en_o, regulator_low_o}, 2'h2);
    cpu_irq_i <= 1'b1;
    wake(20);
    enter(32'h93);
    check("regulator low", regulator_low_o, 1'b1);
    cpu_irq_i <= 1'b1;
    wake(20);
    check("regulator low", regulator_low_o, 1'b0);
    wr(`LPM_OFS_WAKE_EN, 32'h1f);
    enter(32'hd4);
    check("stop clocks", {clk_st, regulator_low_o}, 7'h03);
    clock_domain_event_i[4] <= 1'b1;
    wake(160);
    rd(`LPM_OFS_IRQ_STAT, 32'h4, 32'h4);
    enter(32'hd4);
    external_event_line_i[15] <= 1'b1;
    wake(160);
    enter(32'h94);
    check("stop clocks", {clk_st, regulator_low_o}, 7'h01);
    clock_domain_event_i[4] <= 1'b1;
    settle(200);
    check("cpu clock", cpu_clock_en_o, 1'b0);
    usb_wakeup_i <= 1'b1;
    wake(160);
    // comparator wakes only with the reference on
    enter(32'h94);
    comparator_event_i <= 2'h2;
    settle(20);
    check("cpu clock", cpu_clock_en_o, 1'b0);
    voltage_detector_out_i <= 1'b1;
    wake(160);
    enter(32'h8094);
    comparator_event_i <= 2'h2;
    wake(160);
    enter(32'h95);
    check("standby", {clk_st, regulator_off_o, core_power_off_o}, 8'h3);
    clock_domain_event_i[0] <= 1'b1;
    settle(STBY + 40);
    check("cpu clock", cpu_clock_en_o, 1'b0);
    standby_wake_pin_i[0] <= 1'b1;
    wake(STBY + 40);
    enter(32'h95);
    independent_watchdog_reset_i <= 1'b1;
    settle(STBY + 40);
    check("cpu clock", cpu_clock_en_o, 1'b0);
    external_reset_pin_n_i <= 1'b0;
    wake(STBY + 40);
    enter(32'hd5);
    check("standby", {clk_st, regulator_off_o, core_power_off_o}, 8'h7);
    clock_domain_event_i[0] <= 1'b1;
    wake(STBY + 40);
    // watchdog reset exits standby with clock
    enter(32'hd5);
    independent_watchdog_reset_i <= 1'b1;
    wake(STBY + 40);
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
